/* bench/eeprom_link_sva.sv */
/*
  checker for the two-wire link between the eeprom target and master ends.
  assumes the test top wires it to the shared link and the target status.
*/
`timescale 1ns/1ps
module eeprom_link_sva #(
  parameter int WRITE_CYC = 1500
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  // target status
  input wire logic busy_out,
  input wire logic dormant_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ****************************************
  // busy length counter
  // ****************************************
  int busy_q;
  int busy_d;
  always_comb begin
    busy_d = busy_out ? busy_q + 1 : 0;
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_q <= 0;
    end else begin
      busy_q <= busy_d;
    end
  end
  // ****************************************
  // bus conditions
  // ****************************************
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  // ****************************************
  // properties
  // ****************************************
  ack_edge_a: assert property ($changed(sda_t_oe) |-> !scl)
    else $error("target changed sda while scl high");
  od_drive_a: assert property (sda_t_oe |-> !sda_t_o && !sda)
    else $error("target drove sda high");
  busy_quiet_a: assert property (busy_out |-> !sda_t_oe)
    else $error("target answered while busy");
  busy_start_a: assert property ($rose(busy_out) |-> scl && sda)
    else $error("write cycle began outside idle bus");
  busy_len_a: assert property ($fell(busy_out) |->
    busy_q >= WRITE_CYC - 2 && busy_q <= WRITE_CYC + 2)
    else $error("write cycle length wrong");
  start_free_a: assert property (start_s |=> !sda_t_oe [*2])
    else $error("target drove sda after start");
  stop_free_a: assert property (stop_s |-> !sda_t_oe ##1 !sda_t_oe)
    else $error("target drove sda after stop");
  dormant_idle_a: assert property ($changed(dormant_out) |-> scl && sda)
    else $error("dormant state changed mid transfer");
endmodule

/* bench/eeprom_read_and_ack_polling_test.sv */
/*
  self-checking test of the eeprom target against the master end.
  assumes the master engine and target share one link and clk_in.
*/
`timescale 1ns/1ps
module eeprom_read_and_ack_polling_test;
  import eeprom_link_pkg::*;
  localparam int WCYC = 1500;
  localparam int DCYC = 200;
  localparam logic [6:0] DEV = {TARGET_PREFIX, 3'b101};
  logic       clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_start = 1'b0;
  logic       cmd_stop = 1'b0;
  logic       cmd_read = 1'b0;
  logic       cmd_ack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic       cmd_ready;
  logic       done;
  logic [7:0] rdata;
  logic       acked;
  logic       busy;
  logic       dormant;
  int         fail_count = 0;
  int         cmp_count = 0;
  always #5 clk_in = ~clk_in;
  eeprom_link_if eeprom_link_if_i ();
  eeprom_target #(.WRITE_CYC(WCYC), .DORMANT_CYC(DCYC)) eeprom_target_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(eeprom_link_if_i.target),
    .device_select_pins_in(3'b101), .write_protect_in(1'b0),
    .busy_out(busy), .dormant_out(dormant));
  eeprom_master eeprom_master_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(eeprom_link_if_i.master),
    .cmd_valid_in(cmd_valid), .cmd_start_in(cmd_start), .cmd_stop_in(cmd_stop),
    .cmd_read_in(cmd_read), .cmd_ack_in(cmd_ack), .cmd_data_in(cmd_data),
    .cmd_ready_out(cmd_ready), .done_out(done), .rdata_out(rdata), .acked_out(acked));
  eeprom_link_sva #(.WRITE_CYC(WCYC)) eeprom_link_sva_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl(eeprom_link_if_i.scl),
    .sda(eeprom_link_if_i.sda), .sda_t_o(eeprom_link_if_i.sda_t_o),
    .sda_t_oe(eeprom_link_if_i.sda_t_oe), .busy_out(busy), .dormant_out(dormant));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one byte on the link; waits for done under a bound
  task automatic xfer(input logic st, input logic sp, input logic rd, input logic ak,
                      input logic [7:0] d);
    int n;
    cmd_start <= st;
    cmd_stop  <= sp;
    cmd_read  <= rd;
    cmd_ack   <= ak;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (done !== 1'b1 && n < 4000);
    if (n >= 4000) fail_count++;
    chk("ready", cmd_ready, 1'b1);
    @(posedge clk_in);
  endtask
  task automatic addr_w(input logic [13:0] a);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV, DIR_WRITE});
    chk("dev ack", acked, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, {2'b00, a[13:8]});
    chk("hi ack", acked, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
    chk("lo ack", acked, 1'b1);
  endtask
  // write one byte, then poll until the write cycle ends
  task automatic wr_byte(input logic [13:0] a, input logic [7:0] d);
    int k;
    addr_w(a);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, d);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {DEV, DIR_WRITE});
    chk("busy", busy, 1'b1);
    chk("busy nack", acked, 1'b0);
    k = 0;
    while (acked !== 1'b1 && k < 20) begin
      xfer(1'b1, 1'b1, 1'b0, 1'b0, {DEV, DIR_WRITE});
      k++;
    end
    chk("poll ack", acked, 1'b1);
  endtask
  task automatic rd(input logic ak, input logic [7:0] exp);
    xfer(1'b0, ~ak, 1'b1, ak, 8'h00);
    chk("rdata", rdata, exp);
  endtask
  task automatic open_rd();
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV, DIR_READ});
    chk("rd ack", acked, 1'b1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_poll();
    wr_byte(ADDR_LAST, 8'h5a);
    wr_byte(14'h0000, 8'ha5);
    wr_byte(14'h0001, 8'h3c);
  endtask
  task automatic test_random_current();
    addr_w(ADDR_LAST);
    open_rd();
    rd(1'b0, 8'h5a);
    open_rd();
    rd(1'b0, 8'ha5);
    open_rd();
    rd(1'b0, 8'h3c);
  endtask
  task automatic test_seq();
    addr_w(ADDR_LAST);
    open_rd();
    rd(1'b1, 8'h5a);
    rd(1'b1, 8'ha5);
    rd(1'b0, 8'h3c);
  endtask
  task automatic test_select();
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {TARGET_PREFIX, 3'b100, DIR_WRITE});
    chk("pin nack", acked, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {4'hb, 3'b101, DIR_READ});
    chk("prefix nack", acked, 1'b0);
  endtask
  task automatic test_dormant();
    int n;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV, DIR_WRITE});
    chk("awake ack", acked, 1'b1);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, CMD_DORMANT_TOGGLE);
    repeat (4) @(posedge clk_in);
    chk("dormant on", dormant, 1'b1);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV, DIR_WRITE});
    chk("check nack", acked, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, CMD_DORMANT_CHECK);
    repeat (DCYC + 20) @(posedge clk_in);
    chk("check keeps", dormant, 1'b1);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV, DIR_WRITE});
    chk("toggle nack", acked, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, CMD_DORMANT_TOGGLE);
    n = 0;
    while (dormant !== 1'b0 && n < DCYC + 50) begin
      @(negedge clk_in);
      n++;
    end
    chk("dormant off", dormant, 1'b0);
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #900_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    test_poll();
    test_random_current();
    test_seq();
    test_select();
    test_dormant();
    report_and_stop();
  end
endmodule

/* core/eeprom_link_if.sv */
/*
  two-wire link between target and master: open-drain sda, scl from master.
  assumes the bench instantiates this and both ends on the same clk_in.
*/
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  wire  scl;
  wire  sda;
  // ****************************************
  // wired-and resolution with pull-up
  // ****************************************
  assign scl = (scl_oe & ~scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe & ~sda_m_o) | (sda_t_oe & ~sda_t_o)) ? 1'b0 : 1'b1;
  modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface

/* core/eeprom_link_pkg.sv */
/*
  constants shared by the two-wire eeprom target and its bus master end.
  assumes both ends run on clk_in at 100 mhz and see the same pin wires.
*/
package eeprom_link_pkg;
  // ****************************************
  // addressing
  // ****************************************
  localparam logic [3:0]  TARGET_PREFIX   = 4'ha;
  localparam int          ADDR_W          = 14;
  localparam logic [13:0] ADDR_LAST       = 14'h3fff;
  localparam logic [13:0] ADDR_RESET      = 14'h0000;
  localparam logic        DIR_READ        = 1'b1;
  localparam logic        DIR_WRITE       = 1'b0;
  // ****************************************
  // dormant commands (second byte after a write-direction address)
  // ****************************************
  localparam logic [7:0]  CMD_DORMANT_TOGGLE = 8'hf0;
  localparam logic [7:0]  CMD_DORMANT_CHECK  = 8'hf1;
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_MHZ         = 100;
  localparam int          WRITE_CYCLE_US  = 5000;
  localparam int          WRITE_CYCLES    = WRITE_CYCLE_US * CLK_MHZ;
  localparam int          DORMANT_EXIT_US = 100;
  localparam int          DORMANT_CYCLES  = DORMANT_EXIT_US * CLK_MHZ;
  localparam int          HALF_BIT_DIV    = 8;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
endpackage

/* core/eeprom_master.sv */
/*
  two-wire bus master end: one command per request, byte-level engine.
  assumes link pins come through the shared interface on the same clk_in.
*/
`timescale 1ns/1ps
module eeprom_master
  import eeprom_link_pkg::*;
#(
  parameter int DIV = HALF_BIT_DIV
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // link
  eeprom_link_if.master   link,
  // user command
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_start_in,
  input  wire logic       cmd_stop_in,
  input  wire logic       cmd_read_in,
  input  wire logic       cmd_ack_in,
  input  wire logic [7:0] cmd_data_in,
  output logic            cmd_ready_out,
  // result
  output logic            done_out,
  output logic [7:0]      rdata_out,
  output logic            acked_out
);
  import eeprom_link_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_BIT = 3'b011, M_STOP = 3'b010
  } mstate_t;

  logic [1:0] sda_s_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) sda_s_q <= 2'b11;
    else sda_s_q <= {sda_s_q[0], link.sda};
  end

  // ****************************************
  // bit engine: four quarters per bit, scl made by divider
  // ****************************************
  mstate_t    st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] sh_q, sh_d;
  logic       scl_q, scl_d, sda_q, sda_d;
  logic       stop_q, stop_d, rd_q, rd_d, done_q, done_d, ackd_q, ackd_d;
  logic [7:0] rdat_q, rdat_d;
  wire        tick = (div_q == 8'(DIV - 1));

  always_comb begin
    st_d = st_q; div_d = tick ? 8'h00 : div_q + 8'h01; qtr_d = qtr_q;
    bit_d = bit_q; sh_d = sh_q; scl_d = scl_q; sda_d = sda_q; stop_d = stop_q;
    rd_d = rd_q; done_d = 1'b0; ackd_d = ackd_q; rdat_d = rdat_q;
    case (st_q)
      M_IDLE: begin
        div_d = 8'h00;
        if (cmd_valid_in) begin
          stop_d = cmd_stop_in; rd_d = cmd_read_in; bit_d = 4'h0; qtr_d = 2'h0;
          sh_d = cmd_read_in ? {8'hff, ~cmd_ack_in} : {cmd_data_in, 1'b1};
          st_d = cmd_start_in ? M_START : M_BIT;
        end
      end
      M_START: if (tick) begin
        qtr_d = qtr_q + 2'h1;
        case (qtr_q)
          2'h0: begin sda_d = 1'b1; scl_d = 1'b0; end
          2'h1: scl_d = 1'b1;
          2'h2: sda_d = 1'b0;
          default: begin scl_d = 1'b0; st_d = M_BIT; end
        endcase
      end
      M_BIT: if (tick) begin
        qtr_d = qtr_q + 2'h1;
        case (qtr_q)
          2'h0: sda_d = sh_q[8];
          2'h1: scl_d = 1'b1;
          2'h2: begin
            sh_d = {sh_q[7:0], sda_s_q[1]};
            if (bit_q == 4'h8) ackd_d = ~sda_s_q[1];
          end
          default: begin
            scl_d = 1'b0;
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              rdat_d = sh_q[8:1];
              st_d = stop_q ? M_STOP : M_IDLE;
              done_d = !stop_q;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        qtr_d = qtr_q + 2'h1;
        case (qtr_q)
          2'h0: sda_d = 1'b0;
          2'h1: scl_d = 1'b1;
          2'h2: sda_d = 1'b1;
          default: begin st_d = M_IDLE; done_d = 1'b1; end
        endcase
      end
      default: st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= M_IDLE; div_q <= 8'h00; qtr_q <= 2'h0; bit_q <= 4'h0;
      sh_q <= 9'h1ff; scl_q <= 1'b1; sda_q <= 1'b1; stop_q <= 1'b0;
      rd_q <= 1'b0; done_q <= 1'b0; ackd_q <= 1'b0; rdat_q <= BYTE_RESET;
    end else begin
      st_q <= st_d; div_q <= div_d; qtr_q <= qtr_d; bit_q <= bit_d;
      sh_q <= sh_d; scl_q <= scl_d; sda_q <= sda_d; stop_q <= stop_d;
      rd_q <= rd_d; done_q <= done_d; ackd_q <= ackd_d; rdat_q <= rdat_d;
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~scl_q;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~sda_q;
  assign cmd_ready_out = (st_q == M_IDLE);
  assign done_out      = done_q;
  assign rdata_out     = rdat_q;
  assign acked_out     = ackd_q;
endmodule

/* core/eeprom_target.sv */
/*
  two-wire eeprom target: ack polling, address counter, reads, dormant acks.
  assumes scl and sda come asynchronously and are sampled on clk_in.
*/
// Function
// - no ack to write address while busy
// - ack again once write cycle done
// - master polls address until acknowledged
// - read direction bit one; three read forms
// - counter holds last accessed plus one (code: a write wraps within its 64-byte page)
// - current read acks, sends counter byte
// - master nacks then stops single read
// - after last location, read gives zero
// - random read: dummy write then restart
// - dummy write loads counter, read sends it
// - master ack requests next byte
// - counter increments per sequential byte
// - counter wraps 16383 to zero
// - master nacks last byte then stops
// - dormant toggle nacked if dormant, exits
// - dormant check nacked if dormant, no change
// - address prefix 1010 plus select pins
// - word address sent as two bytes
`timescale 1ns/1ps
module eeprom_target
  import eeprom_link_pkg::*;
#(
  parameter int WRITE_CYC  = WRITE_CYCLES,
  parameter int DORMANT_CYC = DORMANT_CYCLES
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // link
  eeprom_link_if.target   link,
  // straps and status
  input  wire logic [2:0] device_select_pins_in,
  input  wire logic       write_protect_in,
  output logic            busy_out,
  output logic            dormant_out
);
  import eeprom_link_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_RECV = 3'b001, T_ACK = 3'b011, T_SEND = 3'b010,
    T_MACK = 3'b110, T_SKIP = 3'b111
  } tstate_t;
  typedef enum logic [1:0] {
    P_DEV = 2'b00, P_AHI = 2'b01, P_ALO = 2'b11, P_DATA = 2'b10
  } phase_t;

  logic [7:0] mem_q [0:(1<<ADDR_W)-1];

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_p_q;
  logic       sda_p_q;
  // straps are pins too, so they pass two flops like scl and sda
  logic [5:0] sel_s_q;
  logic [1:0] wp_s_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      sel_s_q <= 6'h00;
      wp_s_q  <= 2'b00;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      sel_s_q <= {sel_s_q[2:0], device_select_pins_in};
      wp_s_q  <= {wp_s_q[0], write_protect_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire scl_r = scl_s_q[1] & ~scl_p_q;
  wire scl_f = ~scl_s_q[1] & scl_p_q;
  wire start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  wire stop  = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

  function automatic logic [13:0] next_addr(input logic [13:0] a);
    next_addr = (a == ADDR_LAST) ? ADDR_RESET : a + 14'h0001;
  endfunction

  // ****************************************
  // protocol state
  // ****************************************
  tstate_t     st_q, st_d;
  phase_t      ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [13:0] cnt_q, cnt_d;
  logic [5:0]  ahi_q, ahi_d;
  logic        ack_q, ack_d;
  logic        rd_q, rd_d;
  logic        oe_q, oe_d;
  logic        wr_q, wr_d;
  logic        wpend_q, wpend_d;
  logic        xpend_q, xpend_d;
  logic [31:0] tmr_q, tmr_d;
  logic        dorm_q, dorm_d;
  logic        exit_q, exit_d;
  logic        epend_q, epend_d;
  logic        we;

  always_comb begin
    st_d = st_q; ph_d = ph_q; bit_d = bit_q; sh_d = sh_q; cnt_d = cnt_q;
    ahi_d = ahi_q; ack_d = ack_q; rd_d = rd_q; oe_d = oe_q; wr_d = wr_q;
    wpend_d = wpend_q; xpend_d = xpend_q; tmr_d = tmr_q; dorm_d = dorm_q;
    exit_d = exit_q; we = 1'b0;
    epend_d = epend_q;
    // internal write and dormant-exit timers
    if (wr_q) begin
      if (tmr_q == 32'h0) wr_d = 1'b0;
      else tmr_d = tmr_q - 32'h1;
    end else if (exit_q) begin
      if (tmr_q == 32'h0) begin
        exit_d = 1'b0;
        dorm_d = 1'b0;
      end else tmr_d = tmr_q - 32'h1;
    end
    if (start) begin
      st_d = T_RECV; ph_d = P_DEV; bit_d = 4'h0; oe_d = 1'b0; xpend_d = 1'b0;
      epend_d = 1'b0;
    end else if (stop) begin
      st_d = T_IDLE; oe_d = 1'b0;
      if (wpend_q) begin
        wr_d = 1'b1;
        tmr_d = 32'(WRITE_CYC);
      end
      if (xpend_q) begin
        exit_d = 1'b1;
        tmr_d = 32'(DORMANT_CYC);
      end
      // entry waits for the stop so the dormant state is only entered on an idle bus; exit follows the timer
      if (epend_q) dorm_d = 1'b1;
      wpend_d = 1'b0; xpend_d = 1'b0;
      epend_d = 1'b0;
    end else begin
      case (st_q)
        T_RECV: begin
          if (scl_r) begin
            sh_d = {sh_q[6:0], sda_s_q[1]};
            bit_d = bit_q + 4'h1;
          end
          if (scl_f && bit_q == 4'h8) begin
            ack_d = 1'b0; st_d = T_ACK; bit_d = 4'h0;
            case (ph_q)
              P_DEV: begin
                rd_d = sh_q[0];
                if (sh_q[7:4] == TARGET_PREFIX && sh_q[3:1] == sel_s_q[5:3]
                    && !wr_q && !exit_q) begin
                  if (!(sh_q[0] == DIR_WRITE && dorm_q)) ack_d = 1'b1;
                end else if (sh_q[7:4] != TARGET_PREFIX ||
                             sh_q[3:1] != sel_s_q[5:3]) begin
                  st_d = T_SKIP;
                end
                if (sh_q[7:4] == TARGET_PREFIX && sh_q[3:1] == sel_s_q[5:3]
                    && dorm_q && sh_q[0] == DIR_WRITE) ack_d = 1'b0;
              end
              P_AHI: begin
                if (sh_q == CMD_DORMANT_TOGGLE) begin
                  if (dorm_q) xpend_d = 1'b1;
                  else begin
                    epend_d = 1'b1;
                    ack_d = 1'b1;
                  end
                end else if (sh_q == CMD_DORMANT_CHECK) begin
                  ack_d = !dorm_q;
                end else begin
                  ahi_d = sh_q[5:0];
                  ack_d = !dorm_q;
                end
              end
              P_ALO: begin
                cnt_d = {ahi_q, sh_q};
                ack_d = 1'b1;
              end
              default: begin
                we = !wp_s_q[1];
                wpend_d = !wp_s_q[1];
                cnt_d = {cnt_q[13:6], cnt_q[5:0] + 6'h01};
                ack_d = 1'b1;
              end
            endcase
            oe_d = ack_d;
            if (ack_d) oe_d = 1'b1;
          end
        end
        T_ACK: begin
          oe_d = ack_q;
          if (scl_f) begin
            // a dormant target listens past its withheld ack for the command byte
            if (!ack_q && !(ph_q == P_DEV && rd_q == DIR_WRITE && dorm_q
                            && !wr_q && !exit_q)) begin
              st_d = T_SKIP; oe_d = 1'b0;
            end else if (ph_q == P_DEV && rd_q == DIR_READ) begin
              sh_d = mem_q[cnt_q];
              cnt_d = next_addr(cnt_q);
              oe_d = ~mem_q[cnt_q][7];
              bit_d = 4'h1; st_d = T_SEND;
            end else begin
              oe_d = 1'b0; st_d = T_RECV;
              ph_d = (ph_q == P_DEV) ? P_AHI : (ph_q == P_AHI) ? P_ALO : P_DATA;
            end
          end
        end
        T_SEND: begin
          if (scl_f) begin
            if (bit_q == 4'h8) begin
              oe_d = 1'b0; st_d = T_MACK;
            end else begin
              oe_d = ~sh_q[3'(4'h7 - bit_q)];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        T_MACK: begin
          if (scl_r) ack_d = ~sda_s_q[1];
          if (scl_f) begin
            if (ack_q) begin
              sh_d = mem_q[cnt_q];
              cnt_d = next_addr(cnt_q);
              oe_d = ~mem_q[cnt_q][7];
              bit_d = 4'h1; st_d = T_SEND;
            end else st_d = T_SKIP;
          end
        end
        T_SKIP: oe_d = 1'b0;
        default: st_d = T_IDLE;
      endcase
    end
    if (ph_q == P_AHI && st_q == T_ACK && dorm_q) oe_d = ack_q & oe_d;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= T_IDLE; ph_q <= P_DEV; bit_q <= 4'h0; sh_q <= BYTE_RESET;
      cnt_q <= ADDR_RESET; ahi_q <= 6'h00; ack_q <= 1'b0; rd_q <= 1'b0;
      oe_q <= 1'b0; wr_q <= 1'b0; wpend_q <= 1'b0; xpend_q <= 1'b0;
      tmr_q <= 32'h0; dorm_q <= 1'b0; exit_q <= 1'b0;
      epend_q <= 1'b0;
    end else begin
      st_q <= st_d; ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d;
      cnt_q <= cnt_d; ahi_q <= ahi_d; ack_q <= ack_d; rd_q <= rd_d;
      oe_q <= oe_d; wr_q <= wr_d; wpend_q <= wpend_d; xpend_q <= xpend_d;
      tmr_q <= tmr_d; dorm_q <= dorm_d; exit_q <= exit_d;
      epend_q <= epend_d;
    end
  end

  // memory has no reset; written bytes land at the current pointer
  always_ff @(posedge clk_in) begin
    if (we) mem_q[cnt_q] <= sh_q;
  end

  assign link.sda_t_o  = 1'b0;
  assign link.sda_t_oe = oe_q;
  assign busy_out      = wr_q;
  assign dormant_out   = dorm_q;
endmodule
